// *** design/ept_pkg.sv ***
/*
  Shared constants and carrier types for the pace threshold and channel
  data register bank. Assumes the converter hands over right-justified
  offset-binary codes and that the host accesses one register at a time.
*/
package ept_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0]  EPT_ADDR_THR     = 8'h0F;
  localparam logic [7:0]  EPT_ADDR_CH1     = 8'h11;
  localparam logic [7:0]  EPT_ADDR_CH2     = 8'h12;
  localparam logic [7:0]  EPT_ADDR_CH3     = 8'h13;
  localparam logic [7:0]  EPT_ADDR_CHEST1  = 8'h14;
  localparam logic [7:0]  EPT_ADDR_CHEST2  = 8'h15;
  localparam int          EPT_NUM_CH       = 5;

  // ==========================================================
  // Field layout and reset values
  localparam int          EPT_THR_CH3_LSB  = 16;
  localparam int          EPT_THR_CH2_LSB  = 8;
  localparam int          EPT_THR_CH1_LSB  = 0;
  localparam int          EPT_THR_FLD_W    = 8;
  localparam int          EPT_SAMP_W       = 24;
  localparam int          EPT_FAST_BITS    = 16;
  localparam int          EPT_WORD_ADDR_LSB = 24;
  localparam logic [23:0] EPT_THR_RESET    = 24'h000000;
  localparam logic [23:0] EPT_SAMP_RESET   = 24'h000000;
  localparam logic [23:0] EPT_SIGN_FLIP    = 24'h800000;
  localparam logic [7:0]  EPT_PAD_BYTE     = 8'h00;
  localparam logic [31:0] EPT_RDATA_IDLE   = 32'h00000000;

  // ==========================================================
  // Input stage modes and output rates
  typedef enum logic [1:0] {
    EPT_MODE_ELECTRODE   = 2'b00,
    EPT_MODE_ANALOG_LEAD = 2'b01,
    EPT_MODE_DIGITAL_LEAD = 2'b10
  } ept_mode_t;

  typedef enum logic [1:0] {
    EPT_RATE_2K   = 2'b00,
    EPT_RATE_16K  = 2'b01,
    EPT_RATE_128K = 2'b10
  } ept_rate_t;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } ept_bus_req_t;

  typedef struct packed {
    logic        valid;
    logic [2:0]  chan;
    logic [23:0] raw;
  } ept_samp_in_t;

  typedef struct packed {
    logic        valid;
    logic [2:0]  chan;
    logic [23:0] data;
  } ept_samp_out_t;

  typedef struct packed {
    logic [7:0] third_channel_pulse_level;
    logic [7:0] second_channel_pulse_level;
    logic [7:0] first_channel_pulse_level;
  } ept_thr_t;

endpackage : ept_pkg

// *** design/ept_sample_fmt.sv ***
/*
  Sample formatter: left-justifies a converter code and applies the
  number format of the input mode, one clock of latency.
  Assumes raw codes are right-justified offset binary.
*/
`timescale 1ns/1ns
`default_nettype none
module ept_sample_fmt
  import ept_pkg::*;
(
  input  wire logic          clk,      // 10 MHz clock
  input  wire logic          rst,      // Async reset, high
  input  wire ept_mode_t     mode,     // Input stage mode
  input  wire ept_rate_t     rate,     // Output data rate
  input  wire ept_samp_in_t  samp_in,  // Raw converter sample
  output var  ept_samp_out_t samp_out  // Formatted sample
);

  typedef struct packed {
    ept_samp_out_t out;
  } ept_fmt_state_t;

  ept_fmt_state_t state;
  ept_fmt_state_t next_state;

  always_comb
  begin
    next_state = state;
    next_state.out.valid = samp_in.valid;
    if (samp_in.valid)
    begin
      next_state.out.chan = samp_in.chan;
      // Fast rate keeps 16 bits, pushed to the top of the field
      if (rate == EPT_RATE_128K)
        next_state.out.data = {samp_in.raw[EPT_FAST_BITS-1:0],
                               EPT_PAD_BYTE};
      else
        next_state.out.data = samp_in.raw;
      // Digital lead: offset binary to two's complement
      if (mode == EPT_MODE_DIGITAL_LEAD)
        next_state.out.data = next_state.out.data ^ EPT_SIGN_FLIP;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state <= '0;
    else
      state <= next_state;
  end

  assign samp_out = state.out;

endmodule : ept_sample_fmt
`default_nettype wire

// *** design/ept_regs.sv ***
/*
  Pace level threshold register and five read-only channel data
  registers, with a frame word port for streaming.
  Assumes a host port master with one-cycle strobes and a converter
  that delivers right-justified offset-binary samples.
*/
`timescale 1ns/1ns
`default_nettype none
module ept_regs
  import ept_pkg::*;
(
  input  wire logic         clk,          // 10 MHz clock
  input  wire logic         rst,          // Async reset, high
  input  wire ept_bus_req_t bus_req,      // Host register request
  output var  logic [31:0]  rdata,        // Read data, cycle after read
  input  wire ept_mode_t    mode,         // Input stage mode
  input  wire ept_rate_t    rate,         // Output data rate
  input  wire logic         frame_mode,   // Streaming frames active
  input  wire ept_samp_in_t samp_in,      // Converter sample
  input  wire logic         frame_req,    // Ask for one frame word
  input  wire logic [2:0]   frame_chan,   // Channel of frame word
  output var  logic         frame_valid,  // Frame word ready pulse
  output var  logic [31:0]  frame_word,   // Frame data word
  output var  logic         frame_short,  // Only bits 31:8 are sent
  output var  ept_thr_t     pace_level    // Threshold to pace logic
);

  // ==========================================================
  // Address helpers
  function automatic logic is_data_addr(input logic [7:0] a);
    is_data_addr = (a >= EPT_ADDR_CH1) && (a <= EPT_ADDR_CHEST2);
  endfunction : is_data_addr

  function automatic logic [2:0] chan_of_addr(input logic [7:0] a);
    logic [7:0] d;
    d = a - EPT_ADDR_CH1;
    chan_of_addr = d[2:0];
  endfunction : chan_of_addr

  function automatic logic [7:0] addr_of_chan(input logic [2:0] c);
    addr_of_chan = EPT_ADDR_CH1 + {5'h00, c};
  endfunction : addr_of_chan

  // ==========================================================
  // State
  typedef struct packed {
    ept_thr_t                   thr;
    logic [EPT_NUM_CH-1:0][23:0] samp;
    logic [31:0]                rdata;
    logic                       frame_valid;
    logic [31:0]                frame_word;
    logic                       frame_short;
  } ept_regs_state_t;

  ept_regs_state_t state;
  ept_regs_state_t next_state;
  ept_samp_out_t   fmt_out;

  ept_sample_fmt u_fmt (
    .clk      (clk),
    .rst      (rst),
    .mode     (mode),
    .rate     (rate),
    .samp_in  (samp_in),
    .samp_out (fmt_out)
  );

  always_comb
  begin
    next_state = state;
    next_state.rdata = EPT_RDATA_IDLE;
    next_state.frame_valid = 1'b0;

    // Threshold bytes stored as written, sign kept for pace logic
    if (bus_req.wr && bus_req.addr == EPT_ADDR_THR)
      next_state.thr = bus_req.wdata[23:0];
    // Data addresses take no write path at all

    // Converter updates only; no host path into samples
    if (fmt_out.valid && fmt_out.chan < 3'(EPT_NUM_CH))
      next_state.samp[fmt_out.chan] = fmt_out.data;

    if (bus_req.rd)
    begin
      if (bus_req.addr == EPT_ADDR_THR)
        next_state.rdata = {EPT_PAD_BYTE, state.thr};
      else if (is_data_addr(bus_req.addr))
        next_state.rdata = {bus_req.addr,
                            state.samp[chan_of_addr(bus_req.addr)]};
      else
        next_state.rdata = EPT_RDATA_IDLE;
    end

    if (frame_req && frame_chan < 3'(EPT_NUM_CH))
    begin
      next_state.frame_valid = 1'b1;
      next_state.frame_word  = {addr_of_chan(frame_chan),
                                state.samp[frame_chan]};
      next_state.frame_short = frame_mode &&
                               (rate == EPT_RATE_128K);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state      <= '0;
      state.thr  <= EPT_THR_RESET;
      state.samp <= {EPT_NUM_CH{EPT_SAMP_RESET}};
    end
    else
      state <= next_state;
  end

  assign rdata       = state.rdata;
  assign frame_valid = state.frame_valid;
  assign frame_word  = state.frame_word;
  assign frame_short = state.frame_short;
  assign pace_level  = state.thr;

  // ==========================================================
  // Checks
  property p_thr_write;
    @(posedge clk) disable iff (rst)
    (bus_req.wr && bus_req.addr == EPT_ADDR_THR)
      |=> (pace_level == $past(bus_req.wdata[23:0]));
  endproperty
  a_thr_write: assert property (p_thr_write)
    else $error("threshold write not stored");

  property p_thr_read;
    @(posedge clk) disable iff (rst)
    (bus_req.rd && bus_req.addr == EPT_ADDR_THR
     && !bus_req.wr)
      |=> (rdata == {EPT_PAD_BYTE, $past(pace_level)});
  endproperty
  a_thr_read: assert property (p_thr_read)
    else $error("threshold read value wrong");

  property p_thr_sign;
    @(posedge clk) disable iff (rst)
    (bus_req.wr && bus_req.addr == EPT_ADDR_THR
     && bus_req.wdata[7:0] == 8'hFF)
      |=> ($signed(pace_level.first_channel_pulse_level) == -8'sd1);
  endproperty
  a_thr_sign: assert property (p_thr_sign)
    else $error("threshold byte lost its sign");

  property p_addr_byte;
    @(posedge clk) disable iff (rst)
    (bus_req.rd && is_data_addr(bus_req.addr))
      |=> (rdata[31:24] == $past(bus_req.addr));
  endproperty
  a_addr_byte: assert property (p_addr_byte)
    else $error("data word address byte wrong");

  property p_fast_justify;
    @(posedge clk) disable iff (rst)
    (samp_in.valid && rate == EPT_RATE_128K && $stable(rate))
      |=> (fmt_out.data[7:0] == EPT_PAD_BYTE)
       ##1 (state.samp[$past(samp_in.chan, 2)][23:8] ==
            ($past(samp_in.raw[15:0], 2) ^
             (($past(mode, 2) == EPT_MODE_DIGITAL_LEAD) ?
              16'h8000 : 16'h0000)))
          || $past(samp_in.chan, 2) >= 3'(EPT_NUM_CH);
  endproperty
  a_fast_justify: assert property (p_fast_justify)
    else $error("fast sample not left justified");

  property p_unsigned;
    @(posedge clk) disable iff (rst)
    (samp_in.valid && rate != EPT_RATE_128K
     && mode != EPT_MODE_DIGITAL_LEAD)
      |=> (fmt_out.data == $past(samp_in.raw));
  endproperty
  a_unsigned: assert property (p_unsigned)
    else $error("unsigned sample altered");

  property p_signed;
    @(posedge clk) disable iff (rst)
    (samp_in.valid && rate != EPT_RATE_128K
     && mode == EPT_MODE_DIGITAL_LEAD)
      |=> (fmt_out.data == ($past(samp_in.raw) ^ EPT_SIGN_FLIP));
  endproperty
  a_signed: assert property (p_signed)
    else $error("digital lead sample not two's complement");

  property p_slow_bits;
    @(posedge clk) disable iff (rst)
    (samp_in.valid && rate == EPT_RATE_2K)
      |=> (fmt_out.data[7:0] == $past(samp_in.raw[7:0]));
  endproperty
  a_slow_bits: assert property (p_slow_bits)
    else $error("slow rate lost low bits");

  property p_reset_clear;
    @(posedge clk)
    $fell(rst) |-> (state.samp == '0) && (rdata == EPT_RDATA_IDLE);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("data not clear after reset");

  property p_frame_short;
    @(posedge clk) disable iff (rst)
    (frame_req && frame_chan < 3'(EPT_NUM_CH))
      |=> frame_valid && (frame_short ==
          ($past(frame_mode) && $past(rate) == EPT_RATE_128K));
  endproperty
  a_frame_short: assert property (p_frame_short)
    else $error("frame length flag wrong");

  property p_ro_write;
    @(posedge clk) disable iff (rst)
    (bus_req.wr && is_data_addr(bus_req.addr) && !fmt_out.valid)
      |=> (state.samp == $past(state.samp));
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("write changed a data register");

  property p_thr_hold;
    @(posedge clk) disable iff (rst)
    !(bus_req.wr && bus_req.addr == EPT_ADDR_THR)
      |=> $stable(pace_level);
  endproperty
  a_thr_hold: assert property (p_thr_hold)
    else $error("threshold changed without a write");

  property p_thr_neg;
    @(posedge clk) disable iff (rst)
    (bus_req.wr && bus_req.addr == EPT_ADDR_THR && bus_req.wdata[23])
      |=> ($signed(pace_level.third_channel_pulse_level) < 8'sd0);
  endproperty
  a_thr_neg: assert property (p_thr_neg)
    else $error("top threshold byte not negative");

  property p_store;
    @(posedge clk) disable iff (rst)
    (fmt_out.valid && fmt_out.chan < 3'(EPT_NUM_CH))
      |=> (state.samp[$past(fmt_out.chan)] == $past(fmt_out.data));
  endproperty
  a_store: assert property (p_store)
    else $error("formatted sample not stored");

  property p_mid_bits;
    @(posedge clk) disable iff (rst)
    (samp_in.valid && rate == EPT_RATE_16K)
      |=> (fmt_out.data[7:0] == $past(samp_in.raw[7:0]));
  endproperty
  a_mid_bits: assert property (p_mid_bits)
    else $error("middle rate lost low bits");

  property p_frame_word;
    @(posedge clk) disable iff (rst)
    (frame_req && frame_chan < 3'(EPT_NUM_CH))
      |=> (frame_word[31:24] == (EPT_ADDR_CH1 + {5'h00, $past(frame_chan)}));
  endproperty
  a_frame_word: assert property (p_frame_word)
    else $error("frame word address byte wrong");

  property p_frame_drop;
    @(posedge clk) disable iff (rst)
    (frame_req && frame_chan >= 3'(EPT_NUM_CH))
      |=> !frame_valid && $stable(frame_word);
  endproperty
  a_frame_drop: assert property (p_frame_drop)
    else $error("frame request for absent channel acted");

  property p_drop_chan;
    @(posedge clk) disable iff (rst)
    (fmt_out.valid && fmt_out.chan >= 3'(EPT_NUM_CH))
      |=> $stable(state.samp);
  endproperty
  a_drop_chan: assert property (p_drop_chan)
    else $error("absent channel sample changed data");

  property p_reset_thr;
    @(posedge clk)
    $fell(rst) |-> (pace_level == EPT_THR_RESET) && !frame_valid;
  endproperty
  a_reset_thr: assert property (p_reset_thr)
    else $error("threshold not clear after reset");

  c_thr_write: cover property (@(posedge clk) disable iff (rst)
    bus_req.wr && bus_req.addr == EPT_ADDR_THR);
  c_data_read: cover property (@(posedge clk) disable iff (rst)
    bus_req.rd && bus_req.addr == EPT_ADDR_CHEST2);
  c_frame_fast: cover property (@(posedge clk) disable iff (rst)
    frame_valid && frame_short);
  c_digital: cover property (@(posedge clk) disable iff (rst)
    samp_in.valid && mode == EPT_MODE_DIGITAL_LEAD);
  c_ro_write: cover property (@(posedge clk) disable iff (rst)
    bus_req.wr && is_data_addr(bus_req.addr));

endmodule : ept_regs
`default_nettype wire

// *** verif/ept_conv_model.sv ***
/*
  Converter stand-in: hands one raw sample to the register bank per send
  pulse, one clock after the request.
  Assumes the bench pulses send for one cycle at a time.
*/
`timescale 1ns/1ns
`default_nettype none
module ept_conv_model
  import ept_pkg::*;
(
  input  wire logic         clk,   // 10 MHz clock
  input  wire logic         rst,   // Async reset, high
  input  wire logic         send,  // Deliver one sample
  input  wire logic [2:0]   chan,  // Channel of the sample
  input  wire logic [23:0]  code,  // Right-justified offset binary
  output var  ept_samp_in_t samp   // Sample towards the bank
);
  // ==========================================================
  // Code bus flips every cycle between samples, stale data and its inverse in turn
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      samp <= '0;
    else
    begin
      samp.valid <= send;
      samp.chan  <= chan;
      samp.raw   <= send ? code : ~samp.raw;
    end
  end
endmodule : ept_conv_model
`default_nettype wire

// *** verif/ept_regs_test.sv ***
/*
  Self-checking bench for the threshold and channel data registers.
  Assumes ept_pkg, ept_regs and ept_conv_model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module ept_regs_test
  import ept_pkg::*;
;
  logic          clk;
  logic          rst;
  ept_bus_req_t  bus_req;
  logic [31:0]   rdata;
  ept_mode_t     mode;
  ept_rate_t     rate;
  logic          frame_mode;
  ept_samp_in_t  samp_in;
  logic          frame_req;
  logic [2:0]    frame_chan;
  logic          frame_valid;
  logic [31:0]   frame_word;
  logic          frame_short;
  ept_thr_t      pace_level;
  logic          send;
  logic [2:0]    s_chan;
  logic [23:0]   s_code;
  logic [7:0]    a;
  logic [23:0]   code;
  int            fail_count;
  int            checked;
  int            cycles = 0;

  ept_regs DUT (.clk(clk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
    .mode(mode), .rate(rate), .frame_mode(frame_mode), .samp_in(samp_in),
    .frame_req(frame_req), .frame_chan(frame_chan),
    .frame_valid(frame_valid), .frame_word(frame_word),
    .frame_short(frame_short), .pace_level(pace_level));
  ept_conv_model conv (.clk(clk), .rst(rst), .send(send), .chan(s_chan),
    .code(s_code), .samp(samp_in));

  always #50 clk = ~clk;

  // ==========================================================
  // Access tasks
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    @(posedge clk);
    bus_req.addr  <= adr;
    bus_req.wdata <= d;
    bus_req.wr    <= 1'b1;
    @(posedge clk);
    bus_req.wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] adr, input logic [31:0] exp,
                    input string what);
    @(posedge clk);
    bus_req.addr <= adr;
    bus_req.rd   <= 1'b1;
    @(posedge clk);
    bus_req.rd   <= 1'b0;
    @(negedge clk);
    check(what, rdata, exp);
    @(negedge clk);
    check("rdata idle", rdata, 32'h00000000);
  endtask : rd

  task automatic samp(input logic [2:0] c, input logic [23:0] v);
    @(posedge clk);
    send   <= 1'b1;
    s_chan <= c;
    s_code <= v;
    @(posedge clk);
    send   <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : samp

  task automatic frm(input logic [2:0] c, input logic [31:0] w,
                     input logic s, input logic v);
    @(posedge clk);
    frame_req  <= 1'b1;
    frame_chan <= c;
    @(posedge clk);
    frame_req  <= 1'b0;
    @(negedge clk);
    check("frame_valid", {31'h0, frame_valid}, {31'h0, v});
    check("frame_word", frame_word, w);
    check("frame_short", {31'h0, frame_short}, {31'h0, s});
  endtask : frm

  function automatic logic [23:0] fmt(input logic [1:0] m,
                                      input logic [1:0] r,
                                      input logic [23:0] raw);
    logic [23:0] d;
    d = (r == EPT_RATE_128K) ? {raw[15:0], 8'h00} : raw;
    if (m == EPT_MODE_DIGITAL_LEAD)
      d[23] = ~d[23];
    return d;
  endfunction : fmt

  task automatic wrap_up;
    $display("checks %0d failures %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      fail_count++;
      wrap_up();
    end
  end

  // ==========================================================
  // Tests
  initial
  begin
    clk = 1'b0; rst = 1'b1; bus_req = '0; mode = EPT_MODE_ELECTRODE;
    rate = EPT_RATE_2K; frame_mode = 1'b0; frame_req = 1'b0;
    frame_chan = 3'h0; send = 1'b0; s_chan = 3'h0; s_code = 24'h0;
    fail_count = 0; checked = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(EPT_ADDR_THR, 32'h00000000, "thr reset");
    for (int i = 0; i < EPT_NUM_CH; i++)
    begin
      a = EPT_ADDR_CH1 + 8'(i);
      rd(a, {a, 24'h000000}, "data reset");
    end
    $display("test reset done");
    wr(EPT_ADDR_THR, 32'hAAFF0180);
    rd(EPT_ADDR_THR, 32'h00FF0180, "thr");
    check("lvl3", 32'($signed(pace_level.third_channel_pulse_level)),
          32'hFFFFFFFF);
    check("lvl2", {24'h0, pace_level.second_channel_pulse_level},
          32'h00000001);
    check("lvl1", {24'h0, pace_level.first_channel_pulse_level},
          32'h00000080);
    wr(8'h10, 32'h00123456);
    rd(8'h10, 32'h00000000, "unmapped");
    rd(EPT_ADDR_THR, 32'h00FF0180, "thr kept");
    wr(EPT_ADDR_THR, 32'h000000FF);
    @(negedge clk);
    check("lvl1 neg", 32'($signed(pace_level.first_channel_pulse_level)),
          32'hFFFFFFFF);
    wr(EPT_ADDR_THR, 32'hAAFF0180);
    $display("test threshold done");
    for (int m = 0; m < 3; m++)
      for (int r = 0; r < 3; r++)
      begin
        @(posedge clk);
        mode <= ept_mode_t'(m);
        rate <= ept_rate_t'(r);
        code = 24'h9C85E1 ^ 24'(m * 24'h418241 + r * 24'h24A813);
        samp(3'((m * 3 + r) % 5), code);
        a = EPT_ADDR_CH1 + 8'((m * 3 + r) % 5);
        rd(a, {a, fmt(2'(m), 2'(r), code)}, "sample");
      end
    $display("test formats done");
    @(posedge clk);
    mode <= EPT_MODE_ELECTRODE;
    rate <= EPT_RATE_2K;
    samp(3'd4, 24'h5A0F3C);
    samp(3'd6, 24'h123456);
    wr(EPT_ADDR_CHEST2, 32'hFFFFFFFF);
    rd(EPT_ADDR_CHEST2, 32'h155A0F3C, "ro data");
    rd(EPT_ADDR_THR, 32'h00FF0180, "thr side");
    $display("test read-only done");
    @(posedge clk);
    frame_mode <= 1'b1;
    rate       <= EPT_RATE_128K;
    samp(3'd4, 24'h00ABCD);
    frm(3'd4, 32'h15ABCD00, 1'b1, 1'b1);
    rd(EPT_ADDR_CHEST2, 32'h15ABCD00, "full word");
    frm(3'd5, 32'h15ABCD00, 1'b1, 1'b0);
    @(posedge clk);
    rate <= EPT_RATE_2K;
    frm(3'd4, 32'h15ABCD00, 1'b0, 1'b1);
    @(posedge clk);
    frame_mode <= 1'b0;
    rate       <= EPT_RATE_128K;
    frm(3'd4, 32'h15ABCD00, 1'b0, 1'b1);
    $display("test frames done");
    wrap_up();
  end
endmodule : ept_regs_test
`default_nettype wire
